// ### core/fds_mode_supervisor.sv
// mode decode, start-up sequencing, power good and thermal flags of the flash driver
//
// Overview of operation
// - mode 00, force 0: converter shut down, load isolated from battery unless high-current mode is selected.
// - mode 01, force 0: LEDs at DC light level under current regulation.
// - mode 10, force 0: flash armed; high-current mode stops inductive stage during strobe.
// - mode 11, or 00 with force: LEDs off, voltage regulation to output voltage code.
// - mode 01, force 1: voltage regulation plus DC light through current sinks.
// - mode 10, force 1: voltage regulation, flash armed, inductive stage stays on.
// - high clamp when high-current mode or voltage code 0101 to 1111.
// - low clamp when direct drive and voltage code 0000 to 0100.
// - start-up begins with current-limited pre-charge until output nears input or 3.3V.
// - direct drive steps 30mA to 250mA after 1ms, full once regulating.
// - balancing off in direct drive start-up, on in high-current start-up.
// - high-current pre-charge target depends on mode; blanking pauses pre-charge.
// - high-current down-mode limit 30mA or 250mA by selection; full once boosting.
// - power-good monitoring only in voltage regulation.
// - in shutdown power-good pin grounded if push-pull, released if open-drain.
// - push-pull pin follows flag; open-drain pulls low for flag 1.
// - flag only inside output window, forced low when voltage regulation suspended.
// - flag held low while excess output energy returns to input.
// - LED temperature sensing in light modes; in mode 11 only if enabled.
// - warm flag set when thermistor below warm threshold; operation continues.
// - overheat latched while regulating LED current; clears mode, sets heat level.
// - heat level follows die temperature except in shutdown, warning only.
// - direct drive blanking drops flash to DC light; safety timer unaffected.
// - thermal shutdown sets heat level, cleared only by software read.
`timescale 1ns/1ps
module fds_mode_supervisor
   import fds_pkg::*;
#(
   parameter int STEP_CYCLES = FDS_STEP_CYCLES
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // apb slave
   input wire fds_apb_req_s apb_req,
   output fds_apb_rsp_s apb_rsp,
   // analog and neighbour inputs
   input wire fds_sense_s sense_in,
   // power stage and led control
   output fds_drive_s drive,
   // power good pin
   output logic power_good_pin_out,
   output logic power_good_pin_oe
);

   typedef struct packed {
      fds_sense_s sync1;
      fds_sense_s sync2;
      logic [1:0] mode;
      logic voltage_mode_force;
      logic valley_limit_select;
      logic output_stage_select;
      logic temp_sense_enable;
      logic [3:0] output_voltage_code;
      logic led_warm_flag;
      logic led_overheat_flag;
      logic heat_sticky;
      logic [1:0] heat_live;
      logic power_good_flag;
      fds_phase_e phase;
      logic [FDS_CNT_W-1:0] step_cnt;
      fds_apb_rsp_s rsp;
      fds_drive_s drv;
      logic pg_out;
      logic pg_oe;
   } fds_state_s;

   fds_state_s state_reg;
   fds_state_s state_next;

   localparam logic [FDS_CNT_W-1:0] STEP_LAST = FDS_CNT_W'(STEP_CYCLES - 1);

   function automatic logic [31:0] fds_ctrl_word(input fds_state_s s);
      logic [31:0] w;
      w = 32'h0;
      w[FDS_MODE_LSB +: 2] = s.mode;
      w[FDS_VMF_BIT] = s.voltage_mode_force;
      w[FDS_VLIM_BIT] = s.valley_limit_select;
      w[FDS_OSS_BIT] = s.output_stage_select;
      w[FDS_TSE_BIT] = s.temp_sense_enable;
      w[FDS_OV_LSB +: 4] = s.output_voltage_code;
      return w;
   endfunction

   function automatic logic [31:0] fds_stat_word(input fds_state_s s);
      logic [31:0] w;
      w = 32'h0;
      w[FDS_WARM_BIT] = s.led_warm_flag;
      w[FDS_HOT_BIT] = s.led_overheat_flag;
      w[FDS_HEAT_LSB +: 2] = s.heat_sticky ? FDS_HEAT_MAX : s.heat_live;
      w[FDS_PG_BIT] = s.power_good_flag;
      w[FDS_PHASE_LSB +: 3] = s.phase;
      return w;
   endfunction

   always_comb
   begin
      fds_sense_s sn;
      logic shutdown;
      logic vm;
      logic cm_only;
      logic light_mode;
      logic hc;
      logic blank;
      logic access;
      logic done;
      logic wr_ctrl;
      logic rd_stat;
      logic hot_event;
      logic [1:0] eff_mode;

      // every local starts defined, whatever path follows
      sn = '0;
      shutdown = 1'b0;
      vm = 1'b0;
      cm_only = 1'b0;
      light_mode = 1'b0;
      hc = 1'b0;
      blank = 1'b0;
      access = 1'b0;
      done = 1'b0;
      wr_ctrl = 1'b0;
      rd_stat = 1'b0;
      hot_event = 1'b0;
      eff_mode = 2'h0;

      state_next = state_reg;
      // first stage feeds only the second stage
      state_next.sync1 = sense_in;
      state_next.sync2 = state_reg.sync1;
      sn = state_reg.sync2;
      hc = sn.high_current_select;
      blank = sn.transmit_blanking_input;

      // apb: one wait state, effect at the completing edge
      access = apb_req.psel && apb_req.penable;
      done = access && state_reg.rsp.pready;
      state_next.rsp.pready = access && !state_reg.rsp.pready;
      state_next.rsp.pslverr = 1'b0;
      state_next.rsp.prdata = 32'h0;
      if (access && !state_reg.rsp.pready)
      begin
         unique case (apb_req.paddr)
            FDS_CTRL_ADDR: state_next.rsp.prdata = fds_ctrl_word(state_reg);
            FDS_STAT_ADDR: state_next.rsp.prdata = fds_stat_word(state_reg);
            default: state_next.rsp.pslverr = 1'b1;
         endcase
         // status word is read-only: a write there is refused and changes nothing
         if (apb_req.pwrite)
         begin
            state_next.rsp.prdata = 32'h0;
            state_next.rsp.pslverr = (apb_req.paddr != FDS_CTRL_ADDR);
         end
      end
      wr_ctrl = done && apb_req.pwrite && apb_req.paddr == FDS_CTRL_ADDR;
      rd_stat = done && !apb_req.pwrite && apb_req.paddr == FDS_STAT_ADDR;

      if (wr_ctrl)
      begin
         state_next.mode = apb_req.pwdata[FDS_MODE_LSB +: 2];
         state_next.voltage_mode_force = apb_req.pwdata[FDS_VMF_BIT];
         state_next.output_stage_select = apb_req.pwdata[FDS_OSS_BIT];
         state_next.temp_sense_enable = apb_req.pwdata[FDS_TSE_BIT];
         state_next.output_voltage_code = apb_req.pwdata[FDS_OV_LSB +: 4];
         // limit selection only accepted from the idle state
         if (state_reg.phase == FDS_PH_OFF)
         begin
            state_next.valley_limit_select = apb_req.pwdata[FDS_VLIM_BIT];
         end
      end

      // decode from the current settings
      eff_mode = state_reg.mode;
      shutdown = eff_mode == FDS_MODE_OFF && !state_reg.voltage_mode_force;
      vm = eff_mode == FDS_MODE_VREG || state_reg.voltage_mode_force;
      light_mode = eff_mode == FDS_MODE_DC || eff_mode == FDS_MODE_FLASH;
      cm_only = light_mode && !state_reg.voltage_mode_force;

      // led temperature supervision
      state_next.drv.temp_sense_on = light_mode
         || (eff_mode == FDS_MODE_VREG && state_reg.temp_sense_enable);
      state_next.led_warm_flag = state_next.drv.temp_sense_on && sn.ts_below_warm;
      hot_event = light_mode && sn.ts_below_hot;
      if (rd_stat)
      begin
         state_next.led_overheat_flag = 1'b0;
         state_next.heat_sticky = 1'b0;
      end
      // a set in the read cycle survives the clear
      if (hot_event)
      begin
         state_next.led_overheat_flag = 1'b1;
         state_next.heat_sticky = 1'b1;
         state_next.mode = FDS_MODE_OFF;
      end
      // die overheating marks the level until software reads it
      if (sn.thermal_shutdown)
      begin
         state_next.heat_sticky = 1'b1;
      end
      state_next.heat_live = shutdown ? 2'h0 : sn.die_heat;
      state_next.drv.heat_detect_on = !shutdown;

      // start-up sequence
      // counter runs only in the low step, so each start-up begins from zero
      state_next.step_cnt = '0;
      unique case (state_reg.phase)
         FDS_PH_OFF:
            if (!shutdown && !sn.thermal_shutdown)
            begin
               state_next.phase = FDS_PH_PRECHARGE;
            end
         FDS_PH_PRECHARGE:
            if (sn.precharge_done && !(hc && blank))
            begin
               state_next.phase = FDS_PH_STEP_LOW;
            end
         FDS_PH_STEP_LOW:
            if (hc)
            begin
               state_next.phase = FDS_PH_STEP_MID;
            end
            else if (state_reg.step_cnt == STEP_LAST)
            begin
               state_next.phase = FDS_PH_STEP_MID;
            end
            else
            begin
               state_next.step_cnt = state_reg.step_cnt + 1'b1;
            end
         FDS_PH_STEP_MID:
            if (hc ? sn.boost_entered : sn.vout_in_regulation)
            begin
               state_next.phase = FDS_PH_FULL;
            end
         FDS_PH_FULL: ;
         // codes above the last phase cannot be reached; fall back to idle
         default: state_next.phase = FDS_PH_OFF;
      endcase
      // mode change to shutdown or overheating restarts the sequence
      if (shutdown || sn.thermal_shutdown || hot_event)
      begin
         state_next.phase = FDS_PH_OFF;
      end

      // current limit per phase
      unique case (state_reg.phase)
         FDS_PH_OFF: state_next.drv.current_limit = hc ? FDS_LIM_PRECHARGE : FDS_LIM_OFF;
         FDS_PH_PRECHARGE:
            state_next.drv.current_limit = (hc && blank) ? FDS_LIM_OFF : FDS_LIM_PRECHARGE;
         FDS_PH_STEP_LOW: state_next.drv.current_limit = FDS_LIM_30MA;
         FDS_PH_STEP_MID:
            if (hc)
            begin
               state_next.drv.current_limit = state_reg.valley_limit_select
                  ? FDS_LIM_250MA : FDS_LIM_30MA;
            end
            else
            begin
               state_next.drv.current_limit = FDS_LIM_250MA;
            end
         FDS_PH_FULL:
            if (hc && blank)
            begin
               state_next.drv.current_limit = FDS_LIM_OFF;
            end
            else
            begin
               state_next.drv.current_limit = state_reg.valley_limit_select
                  ? FDS_LIM_1600MA : FDS_LIM_1150MA;
            end
         default: state_next.drv.current_limit = FDS_LIM_OFF;
      endcase
      state_next.drv.precharge_pause = state_reg.phase == FDS_PH_PRECHARGE && hc && blank;
      state_next.drv.precharge_to_3v3 = !(hc && cm_only);
      // high-current mode keeps the storage capacitor balanced even when idle
      state_next.drv.balance_enable = hc;

      // mode outputs
      state_next.drv.converter_enable = !shutdown && !sn.thermal_shutdown;
      state_next.drv.load_connect = !shutdown || hc;
      state_next.drv.voltage_regulation = vm;
      state_next.drv.current_regulation = cm_only && !sn.thermal_shutdown;
      state_next.drv.led_dc_on = eff_mode == FDS_MODE_DC && !sn.thermal_shutdown;
      state_next.drv.led_flash_armed = eff_mode == FDS_MODE_FLASH
         && !sn.thermal_shutdown;
      // blanking leaves the strobe timer alone, only the level drops
      state_next.drv.led_flash_level = state_next.drv.led_flash_armed && sn.strobe_active
         && !(!hc && blank);
      state_next.drv.inductive_stage_on = state_next.drv.converter_enable
         && !(cm_only && eff_mode == FDS_MODE_FLASH && hc && sn.strobe_active);
      state_next.drv.ovp_high = hc
         || state_reg.output_voltage_code >= FDS_OV_HIGH_CLAMP_MIN;

      // power good
      state_next.drv.pg_monitor_on = vm;
      state_next.power_good_flag = vm && sn.vout_in_pg_window
         && !sn.energy_return;
      if (shutdown)
      begin
         state_next.pg_out = 1'b0;
         state_next.pg_oe = !state_reg.output_stage_select;
      end
      // push-pull drives both levels, open-drain only ever pulls low
      else if (!state_reg.output_stage_select)
      begin
         state_next.pg_out = state_reg.power_good_flag;
         state_next.pg_oe = 1'b1;
      end
      else
      begin
         state_next.pg_out = 1'b0;
         state_next.pg_oe = state_reg.power_good_flag;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_reg <= '0;
         state_reg.mode <= FDS_MODE_RST;
         state_reg.output_voltage_code <= FDS_OV_RST;
         state_reg.phase <= FDS_PH_OFF;
         state_reg.drv.current_limit <= FDS_LIM_OFF;
         state_reg.drv.precharge_to_3v3 <= 1'b1;
         state_reg.pg_oe <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign apb_rsp = state_reg.rsp;
   assign drive = state_reg.drv;
   assign power_good_pin_out = state_reg.pg_out;
   assign power_good_pin_oe = state_reg.pg_oe;

endmodule

// ### core/fds_pkg.sv
// package of constants and carrier types for the flash driver mode supervisor
package fds_pkg;

   // apb register map (byte addresses)
   localparam logic [7:0] FDS_CTRL_ADDR = 8'h00;
   localparam logic [7:0] FDS_STAT_ADDR = 8'h04;

   // control register fields
   localparam int FDS_MODE_LSB = 0;
   localparam int FDS_VMF_BIT = 2;
   localparam int FDS_VLIM_BIT = 3;
   localparam int FDS_OSS_BIT = 4;
   localparam int FDS_TSE_BIT = 5;
   localparam int FDS_OV_LSB = 8;

   // status register fields
   localparam int FDS_WARM_BIT = 0;
   localparam int FDS_HOT_BIT = 1;
   localparam int FDS_HEAT_LSB = 2;
   localparam int FDS_PG_BIT = 4;
   localparam int FDS_PHASE_LSB = 8;

   // reset values and the heat level shown while the sticky flag is set
   localparam logic [1:0] FDS_MODE_RST = 2'h0;
   localparam logic [3:0] FDS_OV_RST = 4'h0;
   localparam logic [1:0] FDS_HEAT_MAX = 2'h3;

   // operating mode codes
   localparam logic [1:0] FDS_MODE_OFF = 2'h0;
   localparam logic [1:0] FDS_MODE_DC = 2'h1;
   localparam logic [1:0] FDS_MODE_FLASH = 2'h2;
   localparam logic [1:0] FDS_MODE_VREG = 2'h3;

   // lowest output voltage code that needs the high over-voltage clamp
   localparam logic [3:0] FDS_OV_HIGH_CLAMP_MIN = 4'h5;

   // start-up step timing
   localparam int FDS_CLK_MHZ = 50;
   localparam int FDS_STEP_TIME_US = 1000;
   localparam int FDS_STEP_CYCLES = FDS_STEP_TIME_US * FDS_CLK_MHZ;
   localparam int FDS_CNT_W = 17;

   typedef enum logic [2:0] {
      FDS_PH_OFF,
      FDS_PH_PRECHARGE,
      FDS_PH_STEP_LOW,
      FDS_PH_STEP_MID,
      FDS_PH_FULL
   } fds_phase_e;

   // valley current limit selection driven to the power stage
   typedef enum logic [2:0] {
      FDS_LIM_PRECHARGE,
      FDS_LIM_30MA,
      FDS_LIM_250MA,
      FDS_LIM_1150MA,
      FDS_LIM_1600MA,
      FDS_LIM_OFF
   } fds_limit_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } fds_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fds_apb_rsp_s;

   // analog comparators and neighbouring blocks, asynchronous to clk_sys
   typedef struct packed {
      logic high_current_select;
      logic transmit_blanking_input;
      logic ts_below_warm;
      logic ts_below_hot;
      logic [1:0] die_heat;
      logic thermal_shutdown;
      logic strobe_active;
      logic precharge_done;
      logic boost_entered;
      logic vout_in_regulation;
      logic vout_in_pg_window;
      logic energy_return;
   } fds_sense_s;

   typedef struct packed {
      logic converter_enable;
      logic load_connect;
      logic current_regulation;
      logic voltage_regulation;
      logic led_dc_on;
      logic led_flash_armed;
      logic led_flash_level;
      logic inductive_stage_on;
      logic ovp_high;
      fds_limit_e current_limit;
      logic balance_enable;
      logic precharge_to_3v3;
      logic precharge_pause;
      logic pg_monitor_on;
      logic temp_sense_on;
      logic heat_detect_on;
   } fds_drive_s;

endpackage

// ### tb/fds_analog_model.sv
// behavioural analog side: thermistor comparators and start-up progress
`timescale 1ns/1ps
module fds_analog_model
   import fds_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // bench controls
   input wire fds_sense_s ext,
   input wire logic [15:0] ts_mv,
   // device side
   input wire fds_drive_s drive,
   output fds_sense_s sense_in
);
   int cnt;
   // progress restarts while the stage is off or unpowered, so each start-up walks all steps
   always @(posedge clk_sys)
   begin
      if (rst || !drive.converter_enable || drive.current_limit == FDS_LIM_OFF)
         cnt <= 0;
      else if (cnt < 99)
         cnt <= cnt + 1;
   end
   always_comb
   begin
      sense_in = ext;
      sense_in.ts_below_warm = ts_mv < 16'd1050;
      sense_in.ts_below_hot = ts_mv < 16'd345;
      sense_in.precharge_done = cnt >= 4;
      sense_in.boost_entered = cnt >= 30;
      sense_in.vout_in_regulation = cnt >= 40;
   end
endmodule

// ### tb/fds_mode_supervisor_checker.sv
// concurrent port checks for the mode supervisor
`timescale 1ns/1ps
module fds_mode_supervisor_checker
   import fds_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // watched ports
   input wire fds_apb_req_s apb_req,
   input wire fds_apb_rsp_s apb_rsp,
   input wire fds_sense_s sense_in,
   input wire fds_drive_s drive,
   input wire logic power_good_pin_out,
   input wire logic power_good_pin_oe
);
   // inputs reach the outputs three edges late: judge only a steady history
   logic [2:0] age_reg;
   logic [3:0] h1_reg;
   logic [3:0] h2_reg;
   logic [3:0] h3_reg;
   logic ok;
   logic hc;
   logic bl;
   logic sb;
   logic hot;
   assign ok = age_reg == 3'h7 && h1_reg == h2_reg && h2_reg == h3_reg;
   assign {hc, bl, sb, hot} = h3_reg;
   always_ff @(posedge clk_sys)
   begin
      age_reg <= rst ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
      h1_reg <= {sense_in.high_current_select, sense_in.transmit_blanking_input,
         sense_in.strobe_active, sense_in.ts_below_hot};
      h2_reg <= h1_reg;
      h3_reg <= h2_reg;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_pready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held past one cycle");
   a_one_wait: assert property (apb_req.psel && apb_req.penable && !$past(apb_req.penable)
      |=> apb_rsp.pready) else $error("no answer after one wait state");
   a_balance_hc: assert property (ok |-> drive.balance_enable == hc)
      else $error("balancing does not follow high current mode");
   a_ovp_high: assert property (ok && hc |-> drive.ovp_high)
      else $error("low clamp in high current mode");
   a_strobe_stop: assert property (ok && hc && sb && drive.led_flash_armed
      && !drive.voltage_regulation |-> !drive.inductive_stage_on)
      else $error("inductive stage on during strobe");
   a_strobe_run: assert property (ok && hc && sb && drive.led_flash_armed
      && drive.voltage_regulation |-> drive.inductive_stage_on)
      else $error("inductive stage off during strobe");
   a_blank_drop: assert property (ok && !hc && bl |-> !drive.led_flash_level)
      else $error("flash level kept while blanked");
   a_hot_stop: assert property (ok && hot && drive.temp_sense_on
      && (drive.led_dc_on || drive.led_flash_armed)
      |-> ##[1:4] !drive.led_dc_on && !drive.led_flash_armed)
      else $error("leds kept on when overheated");
   a_sense_leds: assert property (drive.led_dc_on || drive.led_flash_armed
      |-> drive.temp_sense_on)
      else $error("led temperature sensing off");
   a_pg_monitor: assert property (drive.pg_monitor_on == drive.voltage_regulation
      && !(drive.current_regulation && drive.pg_monitor_on))
      else $error("power good monitor outside voltage regulation");
   a_pin_high: assert property (power_good_pin_out |-> power_good_pin_oe)
      else $error("pin high while not driven");
   a_pin_vreg: assert property (power_good_pin_out
      |-> drive.pg_monitor_on || $past(drive.pg_monitor_on))
      else $error("power good shown without regulation");
   c_refused: cover property (apb_rsp.pready && apb_rsp.pslverr);
   c_full_high: cover property (drive.current_limit == FDS_LIM_1600MA);
   c_od_low: cover property (power_good_pin_oe && !power_good_pin_out);
endmodule
bind fds_mode_supervisor fds_mode_supervisor_checker u_chk (.clk_sys(clk_sys), .rst(rst),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .sense_in(sense_in), .drive(drive),
   .power_good_pin_out(power_good_pin_out), .power_good_pin_oe(power_good_pin_oe));

// ### tb/fds_mode_supervisor_bench.sv
// self-checking bench for the flash driver mode supervisor
`timescale 1ns/1ps
module fds_mode_supervisor_bench
   import fds_pkg::*;
;
   localparam int STEP = 8;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   fds_apb_req_s apb_req = '0;
   fds_apb_rsp_s apb_rsp;
   fds_sense_s ext = '0;
   fds_sense_s sense_in;
   fds_drive_s drive;
   logic pg_out;
   logic pg_oe;
   logic [15:0] ts_mv = 16'd1500;
   logic [31:0] rd;
   logic [1:0] px;
   logic err;
   int fails = 0;
   int n_tests = 0;
   int m, f, hc, ov, tse, oss, heat, sd, vr, i, n;
   always #10 clk_sys = ~clk_sys;
   fds_mode_supervisor #(.STEP_CYCLES(STEP)) DUT (.clk_sys(clk_sys), .rst(rst),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .sense_in(sense_in), .drive(drive),
      .power_good_pin_out(pg_out), .power_good_pin_oe(pg_oe));
   fds_analog_model u_far (.clk_sys(clk_sys), .rst(rst), .ext(ext), .ts_mv(ts_mv),
      .drive(drive), .sense_in(sense_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // slave latency is not assumed: hold the request until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      @(posedge clk_sys);
      while (apb_rsp.pready !== 1'b1 && k < 20)
      begin
         k++;
         @(posedge clk_sys);
      end
      chk(k < 20, 1, "apb answer");
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge clk_sys);
   endtask
   // settling covers the two sync flops, the output flop and the pin flop
   task automatic wr(input int md, vf, vl, os, ts, o);
      apb(1'b1, FDS_CTRL_ADDR, (md << FDS_MODE_LSB) | (vf << FDS_VMF_BIT) |
         (vl << FDS_VLIM_BIT) | (os << FDS_OSS_BIT) | (ts << FDS_TSE_BIT) | (o << FDS_OV_LSB));
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic wait_lim(input fds_limit_e l);
      int k;
      k = 0;
      while (drive.current_limit !== l && k < 200)
      begin
         k++;
         @(posedge clk_sys);
      end
      chk(drive.current_limit, l, "limit");
   endtask
   task automatic startup(input int h, input int vl, input fds_limit_e lo, input fds_limit_e hi);
      ext.high_current_select <= h[0];
      ext.transmit_blanking_input <= h[0];
      wr(0, 0, vl, 0, 0, 0);
      wr(h ? 2 : 1, 0, vl, 0, 0, 0);
      if (h == 1)
      begin
         chk(drive.precharge_pause, 1, "pause");
         chk(drive.current_limit, FDS_LIM_OFF, "paused limit");
         ext.transmit_blanking_input <= 1'b0;
      end
      wait_lim(FDS_LIM_PRECHARGE);
      wait_lim(lo);
      if (h == 0)
      begin
         n = 0;
         while (drive.current_limit === FDS_LIM_30MA && n < 100)
         begin
            n++;
            @(posedge clk_sys);
         end
         chk(n, STEP, "low step");
         chk(drive.current_limit, FDS_LIM_250MA, "mid step");
      end
      wait_lim(hi);
      chk(drive.balance_enable, h, "balance");
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      print_verdict;
   end
   initial
   begin
      void'($urandom(13907));
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      apb(1'b0, FDS_CTRL_ADDR, 0);
      chk(rd, 0, "ctrl reset");
      apb(1'b0, FDS_STAT_ADDR, 0);
      chk(rd[10:8], 0, "phase reset");
      apb(1'b0, 8'h08, 0);
      chk(err, 1, "unmapped");
      apb(1'b1, FDS_STAT_ADDR, 32'hffff_ffff);
      chk(err, 1, "status write");
      for (i = 0; i < 16; i++)
      begin
         m = i % 4;
         f = (i / 4) % 2;
         hc = $urandom % 2;
         ov = $urandom % 16;
         tse = $urandom % 2;
         oss = $urandom % 2;
         heat = $urandom % 4;
         sd = m == 0 && f == 0;
         vr = m == 3 || f == 1;
         ext <= '{high_current_select: hc[0], die_heat: heat[1:0], strobe_active: 1'b1,
            vout_in_pg_window: 1'b1, default: 1'b0};
         wr(m, f, 0, oss, tse, ov);
         chk(drive.voltage_regulation, vr, "vreg");
         chk(drive.pg_monitor_on, vr, "pg monitor");
         chk(drive.led_dc_on, m == 1, "dc light");
         chk(drive.led_flash_armed, m == 2, "flash armed");
         chk(drive.ovp_high, hc == 1 || ov >= 5, "clamp");
         chk(drive.current_regulation, (m == 1 || m == 2) && f == 0, "cm");
         chk(drive.load_connect, !sd || hc == 1, "load");
         chk(drive.heat_detect_on, !sd, "heat detect");
         chk(drive.precharge_to_3v3, !(hc == 1 && (m == 1 || m == 2) && f == 0), "target");
         if (hc == 0)
            chk(drive.converter_enable, !sd, "shutdown");
         if (m == 2 && hc == 1)
            chk(drive.inductive_stage_on, f, "inductive");
         if (f == 0)
            chk(drive.temp_sense_on, m == 1 || m == 2 || (m == 3 && tse == 1), "ts");
         px = sd ? {1'b0, oss == 0} : (oss == 0 ? {vr == 1, 1'b1} : {1'b0, vr == 1});
         chk({pg_out, pg_oe}, px, "pg pin");
         apb(1'b0, FDS_STAT_ADDR, 0);
         chk(rd[3:2], sd ? 0 : heat, "heat");
         chk(rd[4], vr, "pg flag");
      end
      wr(3, 0, 0, 0, 0, 0);
      for (i = 0; i < 3; i++)
      begin
         ext.energy_return <= i == 0;
         ext.vout_in_pg_window <= i != 1;
         repeat (6) @(posedge clk_sys);
         apb(1'b0, FDS_STAT_ADDR, 0);
         chk(rd[4], i == 2, "pg window");
      end
      ext.high_current_select <= 1'b0;
      wr(1, 0, 0, 0, 0, 0);
      ts_mv <= 16'd800;
      repeat (6) @(posedge clk_sys);
      apb(1'b0, FDS_STAT_ADDR, 0);
      chk({rd[0], drive.led_dc_on}, 2'h3, "warm");
      ts_mv <= 16'd300;
      repeat (6) @(posedge clk_sys);
      chk(drive.led_dc_on, 0, "hot off");
      apb(1'b0, FDS_CTRL_ADDR, 0);
      chk(rd[1:0], 0, "hot mode");
      apb(1'b0, FDS_STAT_ADDR, 0);
      chk(rd[3:1], 3'h7, "hot flags");
      ts_mv <= 16'd1500;
      apb(1'b0, FDS_STAT_ADDR, 0);
      chk(rd[3:1], 0, "read clear");
      wr(3, 0, 0, 0, 0, 0);
      ext.thermal_shutdown <= 1'b1;
      ext.die_heat <= 2'h1;
      repeat (6) @(posedge clk_sys);
      ext.thermal_shutdown <= 1'b0;
      repeat (6) @(posedge clk_sys);
      apb(1'b0, FDS_STAT_ADDR, 0);
      chk(rd[3:2], 3, "heat sticky");
      apb(1'b0, FDS_STAT_ADDR, 0);
      chk(rd[3:2], 1, "heat live");
      wr(2, 0, 0, 0, 0, 0);
      for (i = 0; i < 2; i++)
      begin
         ext.transmit_blanking_input <= i[0];
         repeat (6) @(posedge clk_sys);
         chk(drive.led_flash_level, i == 0, "blanking");
      end
      startup(0, 0, FDS_LIM_30MA, FDS_LIM_1150MA);
      startup(1, 1, FDS_LIM_250MA, FDS_LIM_1600MA);
      startup(1, 0, FDS_LIM_30MA, FDS_LIM_1150MA);
      print_verdict;
   end
endmodule
